// [verilog/qfp_pipe.sv]
// two stage fetch/execute pipeline timed by four phases
// Functional notes
// RULE_01 - input clock divided by four into four ordered non-overlapping phases
// RULE_02 - an instruction cycle is four phases; each stage takes one cycle
// RULE_03 - program counter increments in phase one of every cycle
// RULE_04 - program word captured at phase four of its fetch cycle
// RULE_05 - fetched word held in instruction register from phase one, executed after
// RULE_06 - data read in phase two, result written in phase four
// RULE_07 - fetch overlaps execute giving one instruction per cycle
// RULE_08 - a jump discards the prefetched word and takes two cycles
// RULE_09 - reset starts at address zero; interrupt entry loads address four
// RULE_10 - program counter is thirteen bits, eight thousand word space
// RULE_11 - after reset start at phase one with no valid instruction executing
// RULE_12 - flushed slot executes as no-operation with no write or status change
`timescale 1ns/1ps
module qfp_pipe
   import qfp_pkg::*;
(
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 reset,
   input  wire logic                 clock_en,
   // interrupt entry request, same clock domain
   input  wire logic                 int_entry,
   // program memory
   output logic [PC_W-1:0]           prog_addr,
   input  wire logic [WORD_W-1:0]    prog_data,
   // data memory
   output logic [DADDR_W-1:0]        data_addr,
   output logic                      data_rd,
   input  wire logic [DATA_W-1:0]    data_rdata,
   output logic                      data_wr,
   output logic [DATA_W-1:0]         data_wdata,
   // phase and status view
   output logic                      phase_one,
   output logic                      phase_two,
   output logic                      phase_three,
   output logic                      phase_four,
   output logic [WORD_W-1:0]         instruction_holding_register,
   output logic                      exec_valid,
   output logic                      status_zero
);
   import qfp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0]        phase_r;
   logic [PC_W-1:0]   pc_r;
   logic [PC_W-1:0]   pc_nxt;
   logic [PC_W-1:0]   fetch_addr_r;
   logic [WORD_W-1:0] ir_r;
   logic              ir_valid_r;
   logic [DATA_W-1:0] operand_r;
   logic [DATA_W-1:0] result;
   logic              zero_r;
   logic              int_pend_r;
   logic              is_jump;
   logic              do_write;
   logic              redirect;
   logic [PC_W-1:0]   target;
   qfp_state_t        state_r;
   qfp_state_t        state_nxt;

   qfp_phase_gen u_phase (
      .clock       (clock),
      .reset       (reset),
      .clock_en    (clock_en),
      .phase_r     (phase_r),
      .phase_one   (phase_one),
      .phase_two   (phase_two),
      .phase_three (phase_three),
      .phase_four  (phase_four)
   );

   // jump decode: top three bits select the absolute jump
   function automatic logic jump_word(input logic [WORD_W-1:0] w);
      return (w & JUMP_MASK) == JUMP_CODE;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // execute side decode
   assign is_jump    = ir_valid_r && jump_word(ir_r);
   assign redirect   = is_jump || int_pend_r;
   assign target     = int_pend_r ? INT_VECTOR : {2'h0, ir_r[10:0]}; // see RULE_09
   // data memory operand at the word's low seven bits is the increment source; simple execute model
   assign result     = operand_r + 8'h01;
   assign do_write   = ir_valid_r && !jump_word(ir_r) && ir_r[7]; // see RULE_12
   assign pc_nxt     = pc_r + 13'h0001; // see RULE_10

   assign prog_addr  = fetch_addr_r; // see RULE_09
   assign data_addr  = ir_r[DADDR_W-1:0];
   assign data_rd    = ir_valid_r && phase_two; // see RULE_06
   assign data_wr    = do_write && phase_four; // see RULE_06
   assign data_wdata = result;
   assign instruction_holding_register = ir_r;
   assign exec_valid = ir_valid_r;
   assign status_zero = zero_r;

   // state only annotates why the execute slot is empty or full
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         QFP_FETCH_ONLY: state_nxt = redirect ? QFP_FLUSH : QFP_RUN;
         QFP_RUN:        state_nxt = redirect ? QFP_FLUSH : QFP_RUN;
         QFP_FLUSH:      state_nxt = redirect ? QFP_FLUSH : QFP_RUN;
         default:        state_nxt = QFP_FETCH_ONLY;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // pc steps in phase one while its old value becomes the fetch address, so the
   // word at the reset vector or at a jump target is the first one fetched
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pc_r         <= RESET_VECTOR; // see RULE_09
         fetch_addr_r <= RESET_VECTOR;
      end else if (clock_en && phase_four && redirect) begin
         pc_r <= target; // see RULE_08
      end else if (clock_en && phase_one) begin
         pc_r         <= pc_nxt; // see RULE_03
         fetch_addr_r <= pc_r; // see RULE_04
      end
   end

   // ir loads at the end of phase four, so it holds through the next phase one
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ir_r       <= NOP_WORD;
         ir_valid_r <= 1'b0; // see RULE_11
         state_r    <= QFP_FETCH_ONLY;
      end else if (clock_en && phase_four) begin
         ir_r       <= redirect ? NOP_WORD : prog_data; // see RULE_05
         ir_valid_r <= !redirect; // see RULE_07
         state_r    <= state_nxt;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         operand_r  <= 8'h00;
         zero_r     <= 1'b0;
         int_pend_r <= 1'b0;
      end else if (clock_en) begin
         if (phase_two && ir_valid_r) begin
            operand_r <= data_rdata; // see RULE_06
         end
         if (phase_four && do_write) begin
            zero_r <= (result == 8'h00); // see RULE_12
         end
         // interrupt waits for a cycle boundary; set wins over the entry clear
         if (int_entry) begin
            int_pend_r <= 1'b1;
         end else if (phase_four) begin
            int_pend_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_jump_exec;
      clock_en && phase_four && is_jump && !int_pend_r;
   endsequence
   sequence s_flush_slot;
      !ir_valid_r [*4];
   endsequence

   chk_jump_flush: assert property (@(posedge clock) disable iff (reset) // see RULE_08
      s_jump_exec |=> s_flush_slot)
      else $error("prefetched word not discarded after jump");
   chk_flush_nowrite: assert property (@(posedge clock) disable iff (reset) // see RULE_12
      !ir_valid_r |-> !data_wr)
      else $error("write from empty slot");
   chk_write_phase: assert property (@(posedge clock) disable iff (reset) // see RULE_06
      data_wr |-> phase_four && ir_valid_r)
      else $error("data write outside phase four");
   chk_read_phase: assert property (@(posedge clock) disable iff (reset) // see RULE_06
      data_rd |-> phase_two)
      else $error("data read outside phase two");
   chk_pc_step: assert property (@(posedge clock) disable iff (reset) // see RULE_03
      !reset && clock_en && phase_one |=> pc_r == $past(pc_r) + 13'h0001)
      else $error("pc did not step in phase one");
   chk_pc_hold: assert property (@(posedge clock) disable iff (reset) // see RULE_03
      clock_en && (phase_two || phase_three) |=> $stable(pc_r))
      else $error("pc moved outside phase one");
   chk_ir_capture: assert property (@(posedge clock) disable iff (reset) // see RULE_05
      clock_en && phase_four && !redirect |=> ir_r == $past(prog_data))
      else $error("ir missed the fetched word");
   chk_int_vector: assert property (@(posedge clock) disable iff (reset) // see RULE_09
      clock_en && phase_four && int_pend_r |=> pc_r == INT_VECTOR)
      else $error("interrupt did not load vector");
   chk_first_cycle: assert property (@(posedge clock) // see RULE_11
      $fell(reset) |-> !ir_valid_r && phase_one && pc_r == RESET_VECTOR)
      else $error("bad state after reset");

   // fetch side: the address in use is the pc value from before its step
   chk_fetch_addr: assert property (@(posedge clock) disable iff (reset) // see RULE_03
      !reset && clock_en && phase_one |=> prog_addr == $past(pc_r))
      else $error("fetch address is not the pre-step pc");
   chk_jump_target: assert property (@(posedge clock) disable iff (reset) // see RULE_08
      s_jump_exec |=> pc_r == $past(target))
      else $error("jump did not load its target");

   // execute side: one slot per four enabled clocks
   chk_stage_span: assert property (@(posedge clock) disable iff (reset) // see RULE_02
      !reset && !(clock_en && phase_four) |=> $stable(ir_r) && $stable(ir_valid_r))
      else $error("execute slot changed inside a cycle");
   chk_issue_rate: assert property (@(posedge clock) disable iff (reset) // see RULE_07
      !reset && clock_en && phase_four && !redirect |=> ir_valid_r)
      else $error("slot left empty without a redirect");
   chk_state_slot: assert property (@(posedge clock) disable iff (reset) // see RULE_11
      ir_valid_r == (state_r == QFP_RUN))
      else $error("slot state and valid flag disagree");

   // status and interrupt bookkeeping
   chk_status_hold: assert property (@(posedge clock) disable iff (reset) // see RULE_12
      !reset && !(clock_en && phase_four && do_write) |=> $stable(zero_r))
      else $error("status changed without a write");
   chk_int_clear: assert property (@(posedge clock) disable iff (reset) // see RULE_09
      !reset && clock_en && phase_four && !int_entry |=> !int_pend_r)
      else $error("interrupt request not cleared at entry");
endmodule

// [verilog/qfp_pkg.sv]
// shared constants for the quad phase fetch/execute pipe
package qfp_pkg;
   localparam int          PC_W          = 13;
   localparam int          WORD_W        = 14;
   localparam int          DATA_W        = 8;
   localparam int          DADDR_W       = 7;
   localparam logic [12:0] RESET_VECTOR  = 13'h0000;
   localparam logic [12:0] INT_VECTOR    = 13'h0004;
   localparam logic [1:0]  PH_ONE        = 2'h0;
   localparam logic [1:0]  PH_TWO        = 2'h1;
   localparam logic [1:0]  PH_THREE      = 2'h2;
   localparam logic [1:0]  PH_FOUR       = 2'h3;
   localparam int          PHASE_COUNT   = 4;
   localparam real         CLOCK_NS      = 50.0;
   localparam logic [13:0] NOP_WORD      = 14'h0000;
   localparam logic [13:0] JUMP_MASK     = 14'h3800;
   localparam logic [13:0] JUMP_CODE     = 14'h2800;
   typedef enum logic [1:0] {QFP_FETCH_ONLY, QFP_RUN, QFP_FLUSH} qfp_state_t;
endpackage

// [verilog/qfp_phase_gen.sv]
// four phase generator dividing the oscillator input by four
`timescale 1ns/1ps
module qfp_phase_gen
   import qfp_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       clock_en,
   // phases
   output logic [1:0]      phase_r,
   output logic            phase_one,
   output logic            phase_two,
   output logic            phase_three,
   output logic            phase_four
);
   logic [1:0] phase_nxt;

   assign phase_nxt   = phase_r + 2'h1;
   assign phase_one   = (phase_r == PH_ONE);
   assign phase_two   = (phase_r == PH_TWO);
   assign phase_three = (phase_r == PH_THREE);
   assign phase_four  = (phase_r == PH_FOUR);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phase_r <= PH_ONE; // see RULE_11
      end else if (clock_en) begin
         phase_r <= phase_nxt; // see RULE_01
      end
   end

   chk_phase_order: assert property (@(posedge clock) disable iff (reset) // see RULE_01
      clock_en && phase_four |=> phase_one)
      else $error("phase four not followed by phase one");
   chk_phase_onehot: assert property (@(posedge clock) disable iff (reset) // see RULE_01
      $onehot({phase_one, phase_two, phase_three, phase_four}))
      else $error("phases overlap");
endmodule

// [dv/qfp_mem_model.sv]
// program and data memory arrays facing the pipe
`timescale 1ns/1ps
module qfp_mem_model
   import qfp_pkg::*;
(
   // clock
   input  wire logic                 clock,
   // program memory
   input  wire logic [PC_W-1:0]      prog_addr,
   output logic [WORD_W-1:0]         prog_data,
   // data memory
   input  wire logic [DADDR_W-1:0]   data_addr,
   input  wire logic                 data_rd,
   output logic [DATA_W-1:0]         data_rdata,
   input  wire logic                 data_wr,
   input  wire logic [DATA_W-1:0]    data_wdata
);
   logic [WORD_W-1:0] prog_mem [0:2**PC_W-1];
   logic [DATA_W-1:0] data_mem [0:2**DADDR_W-1];
   logic [DATA_W-1:0] last_r;
   assign prog_data = prog_mem[prog_addr];
   // released read bus shows the inverse of its last value, never a stale copy
   assign data_rdata = data_rd ? data_mem[data_addr] : ~last_r;
   always_ff @(posedge clock) begin
      if (data_rd) last_r <= data_mem[data_addr];
      if (data_wr) data_mem[data_addr] <= data_wdata;
   end
endmodule

// [dv/tb.sv]
// self-checking bench for the quad phase fetch/execute pipe
`timescale 1ns/1ps
module tb;
   import qfp_pkg::*;
   logic                clock, reset, clock_en, int_entry, mon_on, hit;
   logic [PC_W-1:0]     prog_addr, exp_pc, fa_prev;
   logic [WORD_W-1:0]   prog_data, ir, w;
   logic [DADDR_W-1:0]  data_addr;
   logic [DATA_W-1:0]   data_rdata, data_wdata, exp_wd;
   logic                data_rd, data_wr, phase_one, phase_two, phase_three, phase_four;
   logic                exec_valid, status_zero, exp_val, exp_z;
   logic [1:0]          ph;
   logic [2:0]          last_ph;
   logic [15:0]         rnd;
   int                  error_cnt = 0;
   int                  cmp_count = 0;
   qfp_pipe i_qfp_pipe (.clock(clock), .reset(reset), .clock_en(clock_en),
      .int_entry(int_entry), .prog_addr(prog_addr), .prog_data(prog_data),
      .data_addr(data_addr), .data_rd(data_rd), .data_rdata(data_rdata),
      .data_wr(data_wr), .data_wdata(data_wdata), .phase_one(phase_one),
      .phase_two(phase_two), .phase_three(phase_three), .phase_four(phase_four),
      .instruction_holding_register(ir), .exec_valid(exec_valid),
      .status_zero(status_zero));
   qfp_mem_model i_qfp_mem_model (.clock(clock), .prog_addr(prog_addr),
      .prog_data(prog_data), .data_addr(data_addr), .data_rd(data_rd),
      .data_rdata(data_rdata), .data_wr(data_wr), .data_wdata(data_wdata));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
   endfunction
   function automatic logic is_jump(input logic [WORD_W-1:0] v);
      return v[13:11] === 3'h5;
   endfunction
   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic print_verdict;
      $display("counts: %0d compares, %0d errors", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // bench phase count; only advances on enabled edges, so stalls are tracked
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         ph <= 2'h0;
         last_ph <= 3'h4;
         exp_pc <= RESET_VECTOR;
         exp_val <= 1'b0;
         exp_z <= 1'b0;
      end else if (clock_en) ph <= ph + 2'h1;
   end
   always @(negedge clock) begin
      if (mon_on && !reset && {1'b0, ph} != last_ph) begin
         last_ph = {1'b0, ph};
         check({phase_four, phase_three, phase_two, phase_one} === (4'h1 << ph), "phase");
         check(data_rd === (phase_two & exec_valid), "read strobe");
         check(data_wr === (phase_four & exec_valid & ir[7] & !is_jump(ir)), "write strobe");
         if (phase_two) exp_wd = i_qfp_mem_model.data_mem[data_addr] + 8'h01;
         if (data_wr) begin
            check(data_wdata === exp_wd, "write data");
            exp_z = (exp_wd == 8'h00);
         end
         if (phase_one) begin
            check(exec_valid === exp_val, "slot valid");
            check(status_zero === exp_z, "zero status");
            if (exp_val) check(ir === i_qfp_mem_model.prog_mem[fa_prev], "word");
         end
         if (phase_two) begin
            check(prog_addr === exp_pc, "fetch address");
            fa_prev = exp_pc;
            exp_val = !(exp_val && is_jump(ir));
            exp_pc = exp_val ? exp_pc + 13'h0001 : {2'h0, ir[10:0]};
         end
      end
   end
   initial begin
      repeat (2000) @(posedge clock);
      error_cnt++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      clock_en = 1'b1;
      int_entry = 1'b0;
      mon_on = 1'b1;
      hit = 1'b0;
      rnd = 16'h3C72;
      for (int a = 0; a < 2**PC_W; a++) begin
         rnd = lfsr_next(rnd);
         w = rnd[13:0];
         if (is_jump(w)) w[13] = 1'b0;
         i_qfp_mem_model.prog_mem[a] = w;
         if (a < 2**DADDR_W) i_qfp_mem_model.data_mem[a] = rnd[15:8];
      end
      // back-to-back jumps, and an operand that wraps to zero
      i_qfp_mem_model.prog_mem[20] = JUMP_CODE | 14'h07F0;
      i_qfp_mem_model.prog_mem[13'h07F0] = JUMP_CODE | 14'h0030;
      i_qfp_mem_model.prog_mem[5][7] = 1'b1;
      i_qfp_mem_model.data_mem[i_qfp_mem_model.prog_mem[5][6:0]] = 8'hFF;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      repeat (400) @(posedge clock) begin
         rnd = lfsr_next(rnd);
         clock_en <= (rnd[1:0] != 2'h0);
      end
      $display("test run with stalls and jumps done");
      clock_en <= 1'b1;
      mon_on = 1'b0;
      @(posedge clock);
      int_entry <= 1'b1;
      @(posedge clock);
      int_entry <= 1'b0;
      repeat (12) @(negedge clock) if (phase_one && prog_addr === INT_VECTOR) hit = 1'b1;
      check(hit, "interrupt vector");
      $display("test interrupt entry done");
      @(posedge clock);
      reset <= 1'b1;
      @(negedge clock);
      check(phase_one === 1'b1 && prog_addr === RESET_VECTOR && exec_valid === 1'b0, "reset");
      mon_on = 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      repeat (100) @(posedge clock);
      $display("test reset in mid-run done");
      print_verdict();
   end
endmodule
